/* File: include/ctab_pkg.sv */
`default_nettype none

package ctab_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W    = 10;
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned NUM_TRIM  = 6;
  localparam int unsigned IDX_W     = 3;
  localparam int unsigned SKEW_W    = 8;
  localparam int unsigned DC_W      = 12;

  // trim register offsets
  localparam logic [ADDR_W-1:0] SECOND_CORE_SINGLE_FIRST_INPUT_SKEW_OFS  = 10'h315;
  localparam logic [ADDR_W-1:0] FIRST_CORE_SINGLE_SECOND_INPUT_SKEW_OFS  = 10'h31a;
  localparam logic [ADDR_W-1:0] SECOND_CORE_SINGLE_SECOND_INPUT_SKEW_OFS = 10'h31b;
  localparam logic [ADDR_W-1:0] FIRST_CORE_DUAL_FIRST_INPUT_DC_TRIM_OFS  = 10'h344;
  localparam logic [ADDR_W-1:0] FIRST_CORE_DUAL_SECOND_INPUT_DC_TRIM_OFS = 10'h346;
  localparam logic [ADDR_W-1:0] FIRST_CORE_SINGLE_FIRST_INPUT_DC_TRIM_OFS = 10'h348;

  // control and status offsets
  localparam logic [ADDR_W-1:0] TRIM_CTRL_OFS   = 10'h3f0;
  localparam logic [ADDR_W-1:0] TRIM_STATUS_OFS = 10'h3f1;

  // storage slot of each trim register
  localparam logic [IDX_W-1:0] IDX_B_SINGLE_FIRST_SKEW  = 3'h0;
  localparam logic [IDX_W-1:0] IDX_A_SINGLE_SECOND_SKEW = 3'h1;
  localparam logic [IDX_W-1:0] IDX_B_SINGLE_SECOND_SKEW = 3'h2;
  localparam logic [IDX_W-1:0] IDX_A_DUAL_FIRST_DC      = 3'h3;
  localparam logic [IDX_W-1:0] IDX_A_DUAL_SECOND_DC     = 3'h4;
  localparam logic [IDX_W-1:0] IDX_A_SINGLE_FIRST_DC    = 3'h5;
  localparam logic [IDX_W-1:0] IDX_LAST                 = 3'h5;
  localparam logic [IDX_W-1:0] IDX_NONE                 = 3'h7;

  // field layouts
  localparam logic [DATA_W-1:0] SKEW_MASK     = 16'h00ff;
  localparam logic [DATA_W-1:0] DC_REG_MASK   = 16'hffff;
  localparam logic [DATA_W-1:0] DC_FIELD_MASK = 16'h0fff;
  localparam logic [DATA_W-1:0] TRIM_RESET    = 16'h0000;

  // control register bits
  localparam int unsigned CTRL_DUAL_BIT   = 0;
  localparam int unsigned CTRL_FGCAL_BIT  = 1;
  localparam int unsigned CTRL_RELOAD_BIT = 2;
  localparam logic        CTRL_DUAL_RST   = 1'b0;
  localparam logic        CTRL_FGCAL_RST  = 1'b0;

  // status register bits
  localparam int unsigned STAT_DONE_BIT    = 0;
  localparam int unsigned STAT_SECOND_BIT  = 1;
  localparam int unsigned STAT_A_SKEW_BIT  = 2;
  localparam int unsigned STAT_B_SKEW_BIT  = 3;
  localparam int unsigned STAT_A_DC_BIT    = 4;

  typedef enum logic [0:0] {
    LD_FUSE,
    LD_RUN
  } ctab_load_type;

endpackage : ctab_pkg

`default_nettype wire

/* File: src/ctab_bank.sv */
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
`default_nettype none

module ctab_bank #(
  parameter logic [ctab_pkg::DATA_W*ctab_pkg::NUM_TRIM-1:0] FUSE_IMAGE = '0
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_b,
  input  wire logic                          ce,
  input  wire logic [ctab_pkg::ADDR_W-1:0]   addr,
  input  wire logic [ctab_pkg::DATA_W-1:0]   wr_data,
  input  wire logic                          wr_stb,
  input  wire logic                          rd_stb,
  output logic      [ctab_pkg::DATA_W-1:0]   rd_data,
  input  wire logic                          sample_second_input,
  output logic      [ctab_pkg::SKEW_W-1:0]   first_core_skew,
  output logic                               first_core_skew_valid,
  output logic      [ctab_pkg::SKEW_W-1:0]   second_core_skew,
  output logic                               second_core_skew_valid,
  output logic      [ctab_pkg::DC_W-1:0]     first_core_dc_trim,
  output logic                               first_core_dc_trim_valid,
  output logic                               load_done
);

  // address decode: slot index of a trim register, IDX_NONE if not one
  function automatic logic [ctab_pkg::IDX_W-1:0] trim_slot(
    input logic [ctab_pkg::ADDR_W-1:0] a
  );
    case (a)
      ctab_pkg::SECOND_CORE_SINGLE_FIRST_INPUT_SKEW_OFS:   trim_slot = ctab_pkg::IDX_B_SINGLE_FIRST_SKEW;
      ctab_pkg::FIRST_CORE_SINGLE_SECOND_INPUT_SKEW_OFS:   trim_slot = ctab_pkg::IDX_A_SINGLE_SECOND_SKEW;
      ctab_pkg::SECOND_CORE_SINGLE_SECOND_INPUT_SKEW_OFS:  trim_slot = ctab_pkg::IDX_B_SINGLE_SECOND_SKEW;
      ctab_pkg::FIRST_CORE_DUAL_FIRST_INPUT_DC_TRIM_OFS:   trim_slot = ctab_pkg::IDX_A_DUAL_FIRST_DC;
      ctab_pkg::FIRST_CORE_DUAL_SECOND_INPUT_DC_TRIM_OFS:  trim_slot = ctab_pkg::IDX_A_DUAL_SECOND_DC;
      ctab_pkg::FIRST_CORE_SINGLE_FIRST_INPUT_DC_TRIM_OFS: trim_slot = ctab_pkg::IDX_A_SINGLE_FIRST_DC;
      default:                                             trim_slot = ctab_pkg::IDX_NONE;
    endcase
  endfunction : trim_slot

  // writable bits of a slot: skew slots 8 bits, offset slots all 16
  function automatic logic [ctab_pkg::DATA_W-1:0] slot_mask(
    input logic [ctab_pkg::IDX_W-1:0] s
  );
    if (s >= ctab_pkg::IDX_A_DUAL_FIRST_DC) begin
      slot_mask = ctab_pkg::DC_REG_MASK;
    end else begin
      slot_mask = ctab_pkg::SKEW_MASK;
    end
  endfunction : slot_mask

  // bits a fuse word may fill: reserved offset bits stay zero
  function automatic logic [ctab_pkg::DATA_W-1:0] fuse_mask(
    input logic [ctab_pkg::IDX_W-1:0] s
  );
    if (s >= ctab_pkg::IDX_A_DUAL_FIRST_DC) begin
      fuse_mask = ctab_pkg::DC_FIELD_MASK;
    end else begin
      fuse_mask = ctab_pkg::SKEW_MASK;
    end
  endfunction : fuse_mask

  logic [ctab_pkg::DATA_W-1:0] trim_r [ctab_pkg::NUM_TRIM];
  logic [ctab_pkg::DATA_W-1:0] rd_data_r;
  logic [ctab_pkg::IDX_W-1:0]  wr_slot;
  logic [ctab_pkg::IDX_W-1:0]  rd_slot;
  logic                        dual_mode_r;
  logic                        fg_cal_en_r;
  ctab_pkg::ctab_load_type     load_state_r;
  ctab_pkg::ctab_load_type     load_state_nxt;
  logic [ctab_pkg::IDX_W-1:0]  fuse_addr_r;
  logic [ctab_pkg::IDX_W-1:0]  fuse_slot_r;
  logic                        fuse_vld_r;
  logic [ctab_pkg::DATA_W-1:0] fuse_word;
  logic                        load_busy;
  logic                        sw_write;
  logic                        reload_req;
  logic [ctab_pkg::IDX_W-1:0]  a_skew_sel;
  logic [ctab_pkg::IDX_W-1:0]  b_skew_sel;
  logic [ctab_pkg::IDX_W-1:0]  a_dc_sel;
  logic [ctab_pkg::SKEW_W-1:0] first_core_skew_r;
  logic [ctab_pkg::SKEW_W-1:0] second_core_skew_r;
  logic [ctab_pkg::DC_W-1:0]   first_core_dc_trim_r;
  logic                        a_skew_vld_r;
  logic                        b_skew_vld_r;
  logic                        a_dc_vld_r;
  logic                        load_done_r;

  // fuse storage
  ctab_fuse_rom #(
    .WIDTH (ctab_pkg::DATA_W),
    .DEPTH (ctab_pkg::NUM_TRIM),
    .AW    (ctab_pkg::IDX_W),
    .IMAGE (FUSE_IMAGE)
  ) u_fuse (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .ce      (ce),
    .rd_addr (fuse_addr_r),
    .rd_data (fuse_word)
  );

  // bus decode
  assign wr_slot    = trim_slot(addr);
  assign rd_slot    = trim_slot(addr);
  assign load_busy  = (load_state_r == ctab_pkg::LD_FUSE) || fuse_vld_r;
  assign sw_write   = wr_stb && !load_busy;
  assign reload_req = sw_write && (addr == ctab_pkg::TRIM_CTRL_OFS)
                      && wr_data[ctab_pkg::CTRL_RELOAD_BIT];

  // fuse load sequencer next state
  always_comb begin
    load_state_nxt = load_state_r;
    case (load_state_r)
      ctab_pkg::LD_FUSE: begin
        if (fuse_addr_r == ctab_pkg::IDX_LAST) begin
          load_state_nxt = ctab_pkg::LD_RUN;
        end
      end
      ctab_pkg::LD_RUN: begin
        if (reload_req) begin
          load_state_nxt = ctab_pkg::LD_FUSE;
        end
      end
      default: load_state_nxt = ctab_pkg::LD_FUSE;
    endcase
  end

  // fuse load sequencer state and address walk
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      load_state_r <= ctab_pkg::LD_FUSE;
      fuse_addr_r  <= '0;
    end else if (ce) begin
      load_state_r <= load_state_nxt;
      if (load_state_r == ctab_pkg::LD_FUSE && fuse_addr_r != ctab_pkg::IDX_LAST) begin
        fuse_addr_r <= fuse_addr_r + 3'h1;
      end else if (load_state_r != ctab_pkg::LD_FUSE) begin
        fuse_addr_r <= '0;
      end
    end
  end

  // fuse word arrives one cycle after its address
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fuse_vld_r  <= 1'b0;
      fuse_slot_r <= '0;
    end else if (ce) begin
      fuse_vld_r  <= (load_state_r == ctab_pkg::LD_FUSE);
      fuse_slot_r <= fuse_addr_r;
    end
  end

  // load complete flag, cleared while a reload runs
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      load_done_r <= 1'b0;
    end else if (ce) begin
      if (reload_req) begin
        load_done_r <= 1'b0;
      end else if (fuse_vld_r && fuse_slot_r == ctab_pkg::IDX_LAST) begin
        load_done_r <= 1'b1;
      end
    end
  end

  // trim storage: fuse defaults, then software writes
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < ctab_pkg::NUM_TRIM; i++) begin
        trim_r[i] <= ctab_pkg::TRIM_RESET;
      end
    end else if (ce) begin
      if (fuse_vld_r) begin
        trim_r[fuse_slot_r] <= fuse_word & fuse_mask(fuse_slot_r);
      end else if (sw_write && wr_slot != ctab_pkg::IDX_NONE) begin
        trim_r[wr_slot] <= wr_data & slot_mask(wr_slot);
      end
    end
  end

  // mode control bits
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dual_mode_r <= ctab_pkg::CTRL_DUAL_RST;
      fg_cal_en_r <= ctab_pkg::CTRL_FGCAL_RST;
    end else if (ce && sw_write && addr == ctab_pkg::TRIM_CTRL_OFS) begin
      dual_mode_r <= wr_data[ctab_pkg::CTRL_DUAL_BIT];
      fg_cal_en_r <= wr_data[ctab_pkg::CTRL_FGCAL_BIT];
    end
  end

  // read port, data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= '0;
    end else if (ce) begin
      rd_data_r <= '0;
      if (rd_stb) begin
        if (rd_slot != ctab_pkg::IDX_NONE) begin
          rd_data_r <= trim_r[rd_slot];
        end else if (addr == ctab_pkg::TRIM_CTRL_OFS) begin
          rd_data_r[ctab_pkg::CTRL_DUAL_BIT]  <= dual_mode_r;
          rd_data_r[ctab_pkg::CTRL_FGCAL_BIT] <= fg_cal_en_r;
        end else if (addr == ctab_pkg::TRIM_STATUS_OFS) begin
          rd_data_r[ctab_pkg::STAT_DONE_BIT]   <= load_done_r;
          rd_data_r[ctab_pkg::STAT_SECOND_BIT] <= sample_second_input;
          rd_data_r[ctab_pkg::STAT_A_SKEW_BIT] <= a_skew_vld_r;
          rd_data_r[ctab_pkg::STAT_B_SKEW_BIT] <= b_skew_vld_r;
          rd_data_r[ctab_pkg::STAT_A_DC_BIT]   <= a_dc_vld_r;
        end
      end
    end
  end

  // slot in force per core, IDX_NONE when this bank holds none
  always_comb begin
    a_skew_sel = ctab_pkg::IDX_NONE;
    b_skew_sel = ctab_pkg::IDX_NONE;
    a_dc_sel   = ctab_pkg::IDX_NONE;
    if (fg_cal_en_r && load_done_r) begin
      if (dual_mode_r) begin
        a_dc_sel = sample_second_input ? ctab_pkg::IDX_A_DUAL_SECOND_DC
                                       : ctab_pkg::IDX_A_DUAL_FIRST_DC;
      end else if (sample_second_input) begin
        a_skew_sel = ctab_pkg::IDX_A_SINGLE_SECOND_SKEW;
        b_skew_sel = ctab_pkg::IDX_B_SINGLE_SECOND_SKEW;
      end else begin
        b_skew_sel = ctab_pkg::IDX_B_SINGLE_FIRST_SKEW;
        a_dc_sel   = ctab_pkg::IDX_A_SINGLE_FIRST_DC;
      end
    end
  end

  // adjustment values driven to the cores
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      first_core_skew_r    <= '0;
      second_core_skew_r   <= '0;
      first_core_dc_trim_r <= '0;
      a_skew_vld_r         <= 1'b0;
      b_skew_vld_r         <= 1'b0;
      a_dc_vld_r           <= 1'b0;
    end else if (ce) begin
      a_skew_vld_r <= (a_skew_sel != ctab_pkg::IDX_NONE);
      b_skew_vld_r <= (b_skew_sel != ctab_pkg::IDX_NONE);
      a_dc_vld_r   <= (a_dc_sel != ctab_pkg::IDX_NONE);
      first_core_skew_r  <= (a_skew_sel == ctab_pkg::IDX_NONE) ? '0
                            : trim_r[a_skew_sel][ctab_pkg::SKEW_W-1:0];
      second_core_skew_r <= (b_skew_sel == ctab_pkg::IDX_NONE) ? '0
                            : trim_r[b_skew_sel][ctab_pkg::SKEW_W-1:0];
      first_core_dc_trim_r <= (a_dc_sel == ctab_pkg::IDX_NONE) ? '0
                              : trim_r[a_dc_sel][ctab_pkg::DC_W-1:0];
    end
  end

  assign rd_data                  = rd_data_r;
  assign first_core_skew          = first_core_skew_r;
  assign first_core_skew_valid    = a_skew_vld_r;
  assign second_core_skew         = second_core_skew_r;
  assign second_core_skew_valid   = b_skew_vld_r;
  assign first_core_dc_trim       = first_core_dc_trim_r;
  assign first_core_dc_trim_valid = a_dc_vld_r;
  assign load_done                = load_done_r;

  // checks
  a_b_first_skew: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ce && load_done_r && fg_cal_en_r && !dual_mode_r && !sample_second_input
    |=> second_core_skew == $past(trim_r[0][7:0]) && second_core_skew_valid)
    else $error("core two skew not from slot 0");

  a_a_second_skew: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ce && load_done_r && fg_cal_en_r && !dual_mode_r && sample_second_input
    |=> first_core_skew == $past(trim_r[1][7:0]) && first_core_skew_valid)
    else $error("core one skew not from slot 1");

  a_b_second_skew: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ce && load_done_r && fg_cal_en_r && !dual_mode_r && sample_second_input
    |=> second_core_skew == $past(trim_r[2][7:0]))
    else $error("core two skew not from slot 2");

  a_dual_first_dc: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ce && load_done_r && fg_cal_en_r && dual_mode_r && !sample_second_input
    |=> first_core_dc_trim == $past(trim_r[3][11:0]) && first_core_dc_trim_valid)
    else $error("dual first input offset wrong");

  a_dual_second_dc: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ce && load_done_r && fg_cal_en_r && dual_mode_r && sample_second_input
    |=> first_core_dc_trim == $past(trim_r[4][11:0]))
    else $error("dual second input offset wrong");

  a_single_first_dc: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ce && load_done_r && fg_cal_en_r && !dual_mode_r && !sample_second_input
    |=> first_core_dc_trim == $past(trim_r[5][11:0]) && !first_core_skew_valid)
    else $error("single first input offset wrong");

  a_reserved_bits_rw: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ce && sw_write && addr == ctab_pkg::FIRST_CORE_DUAL_FIRST_INPUT_DC_TRIM_OFS
    ##1 ce && rd_stb && addr == ctab_pkg::FIRST_CORE_DUAL_FIRST_INPUT_DC_TRIM_OFS
    |=> rd_data == $past(wr_data, 2))
    else $error("offset register readback lost bits");

  a_fuse_default: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    $rose(load_done_r) |-> trim_r[5] == (FUSE_IMAGE[95:80] & ctab_pkg::DC_FIELD_MASK)
      && trim_r[0] == (FUSE_IMAGE[15:0] & ctab_pkg::SKEW_MASK))
    else $error("fuse default not loaded");

  a_no_cal_idle: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ce && !fg_cal_en_r |=> !first_core_skew_valid && !second_core_skew_valid
      && !first_core_dc_trim_valid && first_core_dc_trim == '0)
    else $error("trim in force without calibration");

  a_read_one_cycle: assert property (
    @(posedge sys_clk) disable iff (!rst_b)
    ce && !rd_stb |=> rd_data == '0)
    else $error("read data stood too long");

endmodule : ctab_bank

`default_nettype wire

/* File: src/ctab_fuse_rom.sv */
`timescale 1ns/10ps
`default_nettype none

// factory fuse image, one word per trim slot, registered read port
module ctab_fuse_rom #(
  parameter int unsigned          WIDTH = 16,
  parameter int unsigned          DEPTH = 6,
  parameter int unsigned          AW    = 3,
  parameter logic [WIDTH*DEPTH-1:0] IMAGE = '0
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic [AW-1:0]    rd_addr,
  output logic      [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] rd_data_r;

  // word select, out-of-range reads return zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= '0;
    end else if (ce) begin
      if (32'(rd_addr) < DEPTH) begin
        rd_data_r <= IMAGE[32'(rd_addr)*WIDTH +: WIDTH];
      end else begin
        rd_data_r <= '0;
      end
    end
  end

  assign rd_data = rd_data_r;

endmodule : ctab_fuse_rom

`default_nettype wire

/* File: tb/ctab_bank_test.sv */
`timescale 1ns/10ps
`default_nettype none

module ctab_bank_test;

  localparam logic [95:0] FUSE = 96'h5123_0a3e_f7c3_0081_3c5a_12a5;

  logic                          sys_clk;
  logic                          rst_b;
  logic                          ce;
  logic [ctab_pkg::ADDR_W-1:0]   addr;
  logic [ctab_pkg::DATA_W-1:0]   wr_data;
  logic                          wr_stb;
  logic                          rd_stb;
  logic [ctab_pkg::DATA_W-1:0]   rd_data;
  logic                          sample_second_input;
  logic [ctab_pkg::SKEW_W-1:0]   first_core_skew;
  logic                          first_core_skew_valid;
  logic [ctab_pkg::SKEW_W-1:0]   second_core_skew;
  logic                          second_core_skew_valid;
  logic [ctab_pkg::DC_W-1:0]     first_core_dc_trim;
  logic                          first_core_dc_trim_valid;
  logic                          load_done;
  logic [ctab_pkg::ADDR_W-1:0]   ofs [0:5];
  logic [15:0]                   mdl [0:5];
  int                            err_total;
  int                            num_checks;

  ctab_bank #(.FUSE_IMAGE(FUSE)) dut (
    .sys_clk                  (sys_clk),
    .rst_b                    (rst_b),
    .ce                       (ce),
    .addr                     (addr),
    .wr_data                  (wr_data),
    .wr_stb                   (wr_stb),
    .rd_stb                   (rd_stb),
    .rd_data                  (rd_data),
    .sample_second_input      (sample_second_input),
    .first_core_skew          (first_core_skew),
    .first_core_skew_valid    (first_core_skew_valid),
    .second_core_skew         (second_core_skew),
    .second_core_skew_valid   (second_core_skew_valid),
    .first_core_dc_trim       (first_core_dc_trim),
    .first_core_dc_trim_valid (first_core_dc_trim_valid),
    .load_done                (load_done)
  );

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [ctab_pkg::ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge sys_clk);
    wr_stb  <= 1'b0;
  endtask : wr

  // read data checked in the one cycle it stands, then back to zero
  task automatic rd(input logic [ctab_pkg::ADDR_W-1:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    chk("rd_data", rd_data, exp);
    @(posedge sys_clk);
    #1;
    chk("rd_data idle", rd_data, 16'h0000);
  endtask : rd

  // write, then read the same address with no gap between the strobes
  task automatic wr_rd(input logic [ctab_pkg::ADDR_W-1:0] a, input logic [15:0] d,
                       input logic [15:0] exp);
    @(posedge sys_clk);
    addr    <= a;
    wr_data <= d;
    wr_stb  <= 1'b1;
    @(posedge sys_clk);
    wr_stb  <= 1'b0;
    rd_stb  <= 1'b1;
    @(posedge sys_clk);
    rd_stb  <= 1'b0;
    #1;
    chk("rd_data back to back", rd_data, exp);
  endtask : wr_rd

  // bounded wait for the fuse load
  task automatic wait_done();
    int n;
    for (n = 0; n < 50 && load_done !== 1'b1; n++) begin
      @(posedge sys_clk);
      #1;
    end
    if (load_done !== 1'b1) begin
      err_total++;
      $display("BAD load_done expected 1 seen %b", load_done);
      stop_test();
    end
  endtask : wait_done

  // set mode, then compare core outputs and status against the selection table
  task automatic sel(input logic cal, input logic dual, input logic second);
    logic [15:0] c;
    logic [15:0] e1;
    logic [15:0] e2;
    logic [15:0] ed;
    logic        v1;
    logic        v2;
    logic        vd;
    c = 16'h0000;
    c[ctab_pkg::CTRL_DUAL_BIT]  = dual;
    c[ctab_pkg::CTRL_FGCAL_BIT] = cal;
    v1 = cal & ~dual & second;
    v2 = cal & ~dual;
    vd = cal & ~(~dual & second);
    e1 = v1 ? (mdl[1] & 16'h00ff) : 16'h0000;
    e2 = v2 ? (mdl[second ? 2 : 0] & 16'h00ff) : 16'h0000;
    ed = !vd ? 16'h0000 : (mdl[dual ? (second ? 4 : 3) : 5] & 16'h0fff);
    wr(ctab_pkg::TRIM_CTRL_OFS, c);
    sample_second_input <= second;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("core1 skew", {8'h00, first_core_skew}, e1);
    chk("core1 skew valid", {15'h0000, first_core_skew_valid}, {15'h0000, v1});
    chk("core2 skew", {8'h00, second_core_skew}, e2);
    chk("core2 skew valid", {15'h0000, second_core_skew_valid}, {15'h0000, v2});
    chk("core1 offset", {4'h0, first_core_dc_trim}, ed);
    chk("core1 offset valid", {15'h0000, first_core_dc_trim_valid}, {15'h0000, vd});
    rd(ctab_pkg::TRIM_STATUS_OFS, {11'h000, vd, v2, v1, second, 1'b1});
  endtask : sel

  initial begin
    int i;
    err_total  = 0;
    num_checks = 0;
    rst_b = 1'b0;
    ce = 1'b1;
    addr = '0;
    wr_data = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    sample_second_input = 1'b0;
    ofs[0] = ctab_pkg::SECOND_CORE_SINGLE_FIRST_INPUT_SKEW_OFS;
    ofs[1] = ctab_pkg::FIRST_CORE_SINGLE_SECOND_INPUT_SKEW_OFS;
    ofs[2] = ctab_pkg::SECOND_CORE_SINGLE_SECOND_INPUT_SKEW_OFS;
    ofs[3] = ctab_pkg::FIRST_CORE_DUAL_FIRST_INPUT_DC_TRIM_OFS;
    ofs[4] = ctab_pkg::FIRST_CORE_DUAL_SECOND_INPUT_DC_TRIM_OFS;
    ofs[5] = ctab_pkg::FIRST_CORE_SINGLE_FIRST_INPUT_DC_TRIM_OFS;
    // fuse defaults: skew keeps 7:0, offset keeps 11:0
    mdl[0] = 16'h00a5;
    mdl[1] = 16'h005a;
    mdl[2] = 16'h0081;
    mdl[3] = 16'h07c3;
    mdl[4] = 16'h0a3e;
    mdl[5] = 16'h0123;
    repeat (9) @(posedge sys_clk);
    #1;
    chk("load_done in reset", {15'h0000, load_done}, 16'h0000);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    wait_done();
    // fuse defaults readable
    for (i = 0; i < 6; i++) begin
      rd(ofs[i], mdl[i]);
    end
    rd(10'h300, 16'h0000);
    $display("test defaults done");
    // overwrite all slots, reserved offset bits kept
    for (i = 0; i < 6; i++) begin
      mdl[i] = (i < 3) ? ((16'hf0f0 + 16'(i)) & 16'h00ff) : (16'hf0f0 + 16'(i));
      wr_rd(ofs[i], 16'hf0f0 + 16'(i), mdl[i]);
      rd(ofs[i], mdl[i]);
    end
    wr(10'h300, 16'hffff);
    rd(10'h300, 16'h0000);
    // clock enable low freezes storage: the write is lost
    @(posedge sys_clk);
    ce <= 1'b0;
    wr(ofs[0], 16'h0033);
    @(posedge sys_clk);
    ce <= 1'b1;
    rd(ofs[0], mdl[0]);
    $display("test readback done");
    // every mode and input, calibration on and off
    for (i = 0; i < 8; i++) begin
      sel(i[2], i[1], i[0]);
    end
    $display("test selection done");
    // fuse reload restores defaults, writes during the load are dropped
    wr(ctab_pkg::TRIM_CTRL_OFS, 16'h0004);
    wr(ofs[3], 16'h5555);
    #1;
    chk("load_done reload", {15'h0000, load_done}, 16'h0000);
    wait_done();
    rd(ofs[3], 16'h07c3);
    rd(ofs[1], 16'h005a);
    rd(ctab_pkg::TRIM_CTRL_OFS, 16'h0000);
    $display("test reload done");
    stop_test();
  end

endmodule : ctab_bank_test

`default_nettype wire
